// >>> hw/sitwu_top.v
// two-wire serial unit: shift register, 4-bit edge counter, output latch,
// clock hold control and start/stop detector behind an axi4-lite slave
// assumes open-drain scl/sda resolved outside, timer_match on clk_sys
//
// Operation
// - as slave, unit stretches scl by pulling it low at transfer start/end.
// - every bit clock advances the counter; overflow marks transfer end.
// - detected start sets the start flag, which may request an interrupt.
// - after start, scl is held low once it falls, until flag cleared.
// - in two-wire mode sda is sampled and shifted in on scl rising edge.
// - after eight bits the counter overflows; in the holding mode scl is forced low.
// - addressed slave acks low; counter preset to 14 rewraps after one bit.
// - direction bit one means slave drives sda; otherwise master drives it.
// - bytes continue until stop or repeated start; nack ends slave reception.
// - start detector sees sda delayed against scl for valid sampling.
// - start detector works only in two-wire modes.
// - start detector is sampled on clk_sys, so it needs the clock running.
// - external clock makes the counter count both scl edges.
// - counter preset to fifteen turns next edge into an overflow interrupt.
// - a software clock strobe advances the counter as a software interrupt.
// - cpu write of data register in a shift cycle wins; no shift.
// - register shifts left on external edge, timer match or software strobe.
// - msb drives data output through latch, open per clock select.
// - shift data reaches sda only with direction set; open latch passes msb.
// - byte copied to receive buffer at transfer end; reads have no side effect.
// - wrap flag set at 15 to 0, cleared by writing one, releases scl.
// - writing one clears the start flag and releases the start hold.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`include "sitwu_regs.vh"

module sitwu_top #(
    parameter AW = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    input wire timer_match,
    output wire irq_req
);

    // sda delay in cycles, rounded up and never below one
    localparam DLY_RAW = (`SITWU_SDA_DLY_NS * `SITWU_CLK_KHZ + 999999) / 1000000;
    localparam SDA_DLY = (DLY_RAW < 1) ? 1 : DLY_RAW;

    ////////////////////////////////////////////////////////////////////////
    // register bus slave
    ////////////////////////////////////////////////////////////////////////

    reg aw_v_r, w_v_r, w_s_r, bvalid_r, rvalid_r;
    reg [AW-1:0] aw_a_r;
    reg [7:0] w_d_r;
    reg [1:0] bresp_r, rresp_r;
    reg [31:0] rdata_r;
    wire do_wr, wr_hit, rd_hit, wr_en, wr_data, wr_stat, wr_ctrl, wr_pins;
    wire [7:0] wdat;
    wire [`SITWU_OFS_HI:0] wofs, rofs;

    // each address and data is held until both are present
    assign s_axi_awready = ~aw_v_r & ~bvalid_r;
    assign s_axi_wready = ~w_v_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    assign do_wr = aw_v_r & w_v_r & ~bvalid_r;
    assign wofs = aw_a_r[`SITWU_OFS_HI:0];
    assign rofs = s_axi_araddr[`SITWU_OFS_HI:0];
    assign wr_hit = ~|aw_a_r[AW-1:`SITWU_OFS_W] &
        (wofs == `SITWU_OFS_DATA || wofs == `SITWU_OFS_BUF ||
         wofs == `SITWU_OFS_STAT || wofs == `SITWU_OFS_CTRL ||
         wofs == `SITWU_OFS_PINS);
    assign rd_hit = ~|s_axi_araddr[AW-1:`SITWU_OFS_W] &
        (rofs == `SITWU_OFS_DATA || rofs == `SITWU_OFS_BUF ||
         rofs == `SITWU_OFS_STAT || rofs == `SITWU_OFS_CTRL ||
         rofs == `SITWU_OFS_PINS);
    // only the low byte lane carries register bits
    assign wr_en = do_wr & wr_hit & w_s_r;
    assign wr_data = wr_en & (wofs == `SITWU_OFS_DATA);
    assign wr_stat = wr_en & (wofs == `SITWU_OFS_STAT);
    assign wr_ctrl = wr_en & (wofs == `SITWU_OFS_CTRL);
    assign wr_pins = wr_en & (wofs == `SITWU_OFS_PINS);
    assign wdat = w_d_r;

    // write channel capture and response
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            aw_v_r <= 1'b0;
            aw_a_r <= {AW{1'b0}};
            w_v_r <= 1'b0;
            w_d_r <= `SITWU_RST_BYTE;
            w_s_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `SITWU_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_v_r <= 1'b1;
                aw_a_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_v_r <= 1'b1;
                w_d_r <= s_axi_wdata[7:0];
                w_s_r <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                aw_v_r <= 1'b0;
                w_v_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `SITWU_RESP_OKAY : `SITWU_RESP_SLVERR;
            end
            else if (bvalid_r & s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and sda delay
    ////////////////////////////////////////////////////////////////////////

    reg [1:0] scl_sync_r, sda_sync_r;
    reg scl_q_r, sda_del_q_r;
    wire scl_s, sda_s, sda_del;
    wire [SDA_DLY:0] sda_chain;

    // two flops per pin; the first is read only by the second
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_r <= 2'b11;
            sda_sync_r <= 2'b11;
            scl_q_r <= 1'b1;
            sda_del_q_r <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_q_r <= scl_s;
            sda_del_q_r <= sda_del;
        end
    end
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign sda_chain[0] = sda_s;

    genvar g;
    generate
        for (g = 0; g < SDA_DLY; g = g + 1)
        begin : g_dly
            reg stage_r;
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    stage_r <= 1'b1;
                else
                    stage_r <= sda_chain[g];
            end
            assign sda_chain[g+1] = stage_r;
        end
    endgenerate
    assign sda_del = sda_chain[SDA_DLY];

    ////////////////////////////////////////////////////////////////////////
    // control state, clock sources, shift register and counter
    ////////////////////////////////////////////////////////////////////////

    reg [7:0] sdr_r, sdr_nxt, buf_r;
    reg [3:0] cnt_r, cnt_nxt, pins_r;
    reg [1:0] wm_r;
    reg sie_r, oie_r, cs1_r, cs0_r, strobe_cnt_r, start_r, wrap_r, stop_r;
    reg start_hold_r, latch_r, scl_oe_r, sda_oe_r, irq_r;
    wire scl_rise, scl_fall, two_wire, sw_clk, tc, tc_mode, shift_evt, cnt_evt, wrap;
    wire start_det, stop_det, start_nxt, ovf_hold, latch_open, coll, scl_low, sda_low;

    assign scl_rise = scl_s & ~scl_q_r;
    assign scl_fall = ~scl_s & scl_q_r;
    assign two_wire = wm_r[1];

    // strobes act on the written value, not on stored state
    assign sw_clk = wr_ctrl & wdat[`SITWU_CT_CLK] & ~wdat[`SITWU_CT_CS1];
    assign tc = wr_ctrl & wdat[`SITWU_CT_TC];
    assign tc_mode = wr_ctrl ? (wdat[`SITWU_CT_CLK] & wdat[`SITWU_CT_CS1]) : strobe_cnt_r;

    // external mode 0 shifts on scl rising edge
    assign shift_evt = cs1_r ? (cs0_r ? scl_fall : scl_rise) :
        (cs0_r ? timer_match : sw_clk);
    assign cnt_evt = cs1_r ? (tc_mode ? tc : (scl_rise | scl_fall)) : shift_evt;

    // cpu write beats a shift in the same cycle
    always @*
    begin
        sdr_nxt = sdr_r;
        if (wr_data)
            sdr_nxt = wdat;
        else if (shift_evt)
            sdr_nxt = {sdr_r[6:0], sda_s};
    end

    // counter advances with each bit clock
    always @*
    begin
        cnt_nxt = cnt_r;
        if (wr_stat)
            cnt_nxt = wdat[`SITWU_ST_CNT_HI:`SITWU_ST_CNT_LO];
        else if (cnt_evt)
            cnt_nxt = cnt_r + `SITWU_CNT_ONE;
    end

    // preset to maximum makes the next edge wrap
    assign wrap = cnt_evt & ~wr_stat & (cnt_r == `SITWU_CNT_MAX);

    // sampled on clk_sys, so it needs the clock running
    assign start_det = two_wire & scl_s & sda_del_q_r & ~sda_del;
    assign stop_det = two_wire & scl_s & ~sda_del_q_r & sda_del;

    // write one clears the start flag
    assign start_nxt = start_det | (start_r & ~(wr_stat & wdat[`SITWU_ST_START]));

    // overflow hold in the holding two-wire mode
    // software presets 14 so one ack bit rewraps here
    assign ovf_hold = (wm_r == `SITWU_WM_TWO_HOLD) & wrap_r;

    // latch closed on the sampling half of an external clock
    assign latch_open = ~cs1_r | (scl_s == cs0_r);
    assign coll = two_wire & (sda_s != latch_r);

    // slave stretching through start or overflow hold
    assign scl_low = (pins_r[`SITWU_PN_SCL_DIR] & ~pins_r[`SITWU_PN_SCL_PORT]) |
        start_hold_r | ovf_hold;
    // shift data reaches sda only when direction is output
    // slave drives read data by setting the sda direction
    assign sda_low = pins_r[`SITWU_PN_SDA_DIR] &
        ~(pins_r[`SITWU_PN_SDA_PORT] & (~two_wire | latch_r));

    // open drain, pins only ever driven low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign irq_req = irq_r;

    // serial datapath, flags and holds
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sdr_r <= `SITWU_RST_BYTE;
            buf_r <= `SITWU_RST_BYTE;
            cnt_r <= `SITWU_RST_CNT;
            start_r <= 1'b0;
            wrap_r <= 1'b0;
            stop_r <= 1'b0;
            start_hold_r <= 1'b0;
            latch_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            sdr_r <= sdr_nxt;
            cnt_r <= cnt_nxt;
            // completed byte copied to receive buffer
            if (wrap)
                buf_r <= sdr_nxt;
            wrap_r <= wrap | (wrap_r & ~(wr_stat & wdat[`SITWU_ST_WRAP]));
            stop_r <= stop_det | (stop_r & ~(wr_stat & wdat[`SITWU_ST_STOP]));
            start_r <= start_nxt;
            // hold from first scl fall after start until flag clear
            start_hold_r <= start_nxt & two_wire & (start_hold_r | scl_fall);
            if (latch_open)
                latch_r <= sdr_nxt[7];
            scl_oe_r <= scl_low;
            sda_oe_r <= sda_low;
            irq_r <= (start_r & sie_r) | (wrap_r & oie_r);
        end
    end

    // control and pin registers; scl port bit toggles on strobe
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sie_r <= 1'b0;
            oie_r <= 1'b0;
            wm_r <= `SITWU_RST_WM;
            cs1_r <= 1'b0;
            cs0_r <= 1'b0;
            strobe_cnt_r <= 1'b0;
            pins_r <= `SITWU_RST_PINS;
        end
        else
        begin
            if (wr_ctrl)
            begin
                sie_r <= wdat[`SITWU_CT_SIE];
                oie_r <= wdat[`SITWU_CT_OIE];
                wm_r <= wdat[`SITWU_CT_WM_HI:`SITWU_CT_WM_LO];
                cs1_r <= wdat[`SITWU_CT_CS1];
                cs0_r <= wdat[`SITWU_CT_CS0];
                strobe_cnt_r <= tc_mode;
            end
            if (wr_pins)
                pins_r <= wdat[3:0];
            else if (tc)
                pins_r[`SITWU_PN_SCL_PORT] <= ~pins_r[`SITWU_PN_SCL_PORT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    ////////////////////////////////////////////////////////////////////////

    reg [7:0] rbyte;

    // reads have no side effects on any flag
    always @*
    begin
        rbyte = 8'h00;
        case (rofs)
            `SITWU_OFS_DATA: rbyte = sdr_r;
            `SITWU_OFS_BUF: rbyte = buf_r;
            `SITWU_OFS_STAT: rbyte = {start_r, wrap_r, stop_r, coll, cnt_r};
            `SITWU_OFS_CTRL: rbyte = {sie_r, oie_r, wm_r, cs1_r, cs0_r, 2'b00};
            `SITWU_OFS_PINS: rbyte = {4'h0, pins_r};
            default: rbyte = 8'h00;
        endcase
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= `SITWU_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else if (s_axi_arvalid & ~rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? `SITWU_RESP_OKAY : `SITWU_RESP_SLVERR;
            rdata_r <= rd_hit ? {24'h00_0000, rbyte} : 32'h0000_0000;
        end
        else if (rvalid_r & s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

// >>> hw/sitwu_regs.vh
// register map, field positions, reset values and timing for the two-wire unit
// assumes the includer compares addresses on their low five bits
`ifndef SITWU_REGS_VH
`define SITWU_REGS_VH

// byte offsets on the register bus
`define SITWU_OFS_DATA 5'h00
`define SITWU_OFS_BUF 5'h04
`define SITWU_OFS_STAT 5'h08
`define SITWU_OFS_CTRL 5'h0c
`define SITWU_OFS_PINS 5'h10
`define SITWU_OFS_HI 4
`define SITWU_OFS_W 5

// status fields
`define SITWU_ST_START 7
`define SITWU_ST_WRAP 6
`define SITWU_ST_STOP 5
`define SITWU_ST_COLL 4
`define SITWU_ST_CNT_HI 3
`define SITWU_ST_CNT_LO 0

// control fields
`define SITWU_CT_SIE 7
`define SITWU_CT_OIE 6
`define SITWU_CT_WM_HI 5
`define SITWU_CT_WM_LO 4
`define SITWU_CT_CS1 3
`define SITWU_CT_CS0 2
`define SITWU_CT_CLK 1
`define SITWU_CT_TC 0

// pin register fields
`define SITWU_PN_SCL_PORT 0
`define SITWU_PN_SDA_PORT 1
`define SITWU_PN_SCL_DIR 2
`define SITWU_PN_SDA_DIR 3

// wire modes
`define SITWU_WM_NONE 2'b00
`define SITWU_WM_THREE 2'b01
`define SITWU_WM_TWO 2'b10
`define SITWU_WM_TWO_HOLD 2'b11

// reset values and counter limits
`define SITWU_RST_BYTE 8'h00
`define SITWU_RST_CNT 4'h0
`define SITWU_RST_WM 2'b00
`define SITWU_RST_PINS 4'h3
`define SITWU_CNT_MAX 4'hf
`define SITWU_CNT_ONE 4'h1

// bus answers
`define SITWU_RESP_OKAY 2'b00
`define SITWU_RESP_SLVERR 2'b10

// timing: system clock rate and the sda delay seen by the start detector
`define SITWU_CLK_KHZ 10000
`define SITWU_SDA_DLY_NS 100

`endif

// >>> tb/sitwu_monitor.sv
// checker for the two-wire unit: bus handshakes, answer timing and pin drive
// assumes it sees only the ports of sitwu_top, attached by the bind below
module sitwu_monitor #(
    parameter AW = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_o,
    input wire sda_o,
    input wire scl_oe,
    input wire irq_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // bus answers stand until taken, and hold off new requests meanwhile
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // answer latency: one edge for reads, two for writes
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    // a hole in the map answers with an error and zero data
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == {{(AW-5){1'b0}}, 5'h14} |=> s_axi_rresp == 2'b10
        && s_axi_rdata == 32'h0) else $error("hole read not refused");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // open drain: the pins only ever pull low
    pins_low_a: assert property (!scl_o && !sda_o)
        else $error("pin drives high");

    cover property ($rose(scl_oe));
    cover property ($rose(irq_req));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind sitwu_top sitwu_monitor #(.AW(AW)) mon_u (
    .clk_sys(clk_sys), .rst(rst), .s_axi_araddr(s_axi_araddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe),
    .irq_req(irq_req)
);

// >>> tb/sitwu_bus_master.sv
// two-wire bus master model: open-drain pulls on scl and sda, 800 ns bit period
// assumes the bench resolves both wires with pull-ups from every party's pull
module sitwu_bus_master (
    input wire scl_w,
    input wire sda_w,
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QTR = 200;

    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // wait scl high, since a slave may still be stretching it
    task automatic rise_scl();
        int n;
        begin
            n = 0;
            scl_pull = 1'b0;
            while (scl_w !== 1'b1 && n < 4000)
            begin
                #10;
                n++;
            end
        end
    endtask

    task automatic start_cond();
        begin
            #37;
            sda_pull = 1'b1;
            #(2*QTR);
            scl_pull = 1'b1;
            #(2*QTR);
        end
    endtask

    // sample in high phase; data only moves while scl is low
    task automatic xfer_bit(input logic b, output logic s);
        begin
            sda_pull = ~b;
            #QTR;
            rise_scl();
            #QTR;
            s = sda_w;
            #QTR;
            scl_pull = 1'b1;
            #QTR;
        end
    endtask

    task automatic send_byte(input logic [7:0] v);
        logic s;
        begin
            for (int i = 7; i >= 0; i--)
                xfer_bit(v[i], s);
        end
    endtask

    task automatic stop_cond();
        begin
            sda_pull = 1'b1;
            #QTR;
            rise_scl();
            #(2*QTR);
            sda_pull = 1'b0;
            #(2*QTR);
        end
    endtask
endmodule

// >>> tb/tb_serial_interface_two_wire_unit.sv
// bench for the two-wire unit: register sequences over axi4-lite plus a bus master
// assumes sitwu_top from hw/ and the master model beside this file
`include "sitwu_regs.vh"
module tb_serial_interface_two_wire_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, timer_match, ack;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, irq_req;
    wire m_scl, m_sda, scl_w, sda_w;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int failures, check_count;

    // wires with pull-ups: low whenever any party pulls
    assign scl_w = ~(scl_oe | m_scl);
    assign sda_w = ~(sda_oe | m_sda);

    sitwu_top #(.AW(8)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .timer_match(timer_match), .irq_req(irq_req)
    );

    sitwu_bus_master m_u (.scl_w(scl_w), .sda_w(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            check_count++;
            if (seen !== exp)
            begin
                failures++;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // each task starts one edge on, so no signal is driven twice in a step
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge clk_sys);
            awaddr <= {3'h0, a};
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge clk_sys);
                n++;
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
            end while (bvalid !== 1'b1 && n < 100);
            if (n >= 100)
                failures++;
            r = bresp;
            bready <= 1'b0;
        end
    endtask

    task automatic reg_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge clk_sys);
            araddr <= {3'h0, a};
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge clk_sys);
                n++;
                if (arready)
                    arvalid <= 1'b0;
            end while (rvalid !== 1'b1 && n < 100);
            if (n >= 100)
                failures++;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [1:0] r;
        reg_wr(a, d, r);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        begin
            reg_rd(a, d, r);
            check({r, d[29:0]}, {`SITWU_RESP_OKAY, 22'h0, e});
        end
    endtask

    task automatic wrap_up();
        begin
            if (failures == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a tenth of this span
    initial
    begin
        #2000000;
        failures++;
        wrap_up();
    end

    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, timer_match} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`SITWU_OFS_STAT, 8'h00);
        rd_chk(`SITWU_OFS_PINS, 8'h03);
        reg_rd(5'h14, rd, resp);
        check({resp, rd[29:0]}, {`SITWU_RESP_SLVERR, 30'h0});
        reg_wr(5'h14, 8'hff, resp);
        check({30'h0, resp}, {30'h0, `SITWU_RESP_SLVERR});
        // two-wire, overflow hold, scl edges clock, start interrupt on
        wr(`SITWU_OFS_CTRL, 8'hb8);
        m_u.start_cond();
        ticks(2);
        rd_chk(`SITWU_OFS_STAT, 8'h81);
        check({31'h0, irq_req}, 32'h1);
        check({31'h0, scl_oe}, 32'h1);
        wr(`SITWU_OFS_STAT, 8'h80);
        ticks(2);
        check({31'h0, scl_oe}, 32'h0);
        m_u.send_byte(8'ha5);
        ticks(3);
        reg_rd(`SITWU_OFS_STAT, rd, resp);
        check(rd & 32'hef, 32'h40);
        check({31'h0, scl_oe}, 32'h1);
        rd_chk(`SITWU_OFS_DATA, 8'ha5);
        wr(`SITWU_OFS_BUF, 8'h5a);
        rd_chk(`SITWU_OFS_BUF, 8'ha5);
        // acknowledge: slave pulls sda, counter preset to fourteen
        wr(`SITWU_OFS_DATA, 8'h00);
        wr(`SITWU_OFS_PINS, 8'h0b);
        ticks(2);
        check({31'h0, sda_oe}, 32'h1);
        wr(`SITWU_OFS_STAT, 8'h4e);
        m_u.xfer_bit(1'b1, ack);
        check({31'h0, ack}, 32'h0);
        ticks(3);
        reg_rd(`SITWU_OFS_STAT, rd, resp);
        check(rd & 32'hef, 32'h40);
        check({31'h0, scl_oe}, 32'h1);
        wr(`SITWU_OFS_PINS, 8'h03);
        wr(`SITWU_OFS_STAT, 8'h40);
        m_u.stop_cond();
        ticks(3);
        reg_rd(`SITWU_OFS_STAT, rd, resp);
        check(rd & 32'hef, 32'h21);
        // software strobe as interrupt source, counter preset to fifteen
        wr(`SITWU_OFS_STAT, 8'hef);
        wr(`SITWU_OFS_CTRL, 8'h40);
        wr(`SITWU_OFS_CTRL, 8'h42);
        ticks(2);
        rd_chk(`SITWU_OFS_STAT, 8'h40);
        rd_chk(`SITWU_OFS_DATA, 8'h01);
        check({31'h0, irq_req}, 32'h1);
        wr(`SITWU_OFS_CTRL, 8'h00);
        ticks(2);
        check({31'h0, irq_req}, 32'h0);
        // timer match as shift clock
        wr(`SITWU_OFS_STAT, 8'h40);
        wr(`SITWU_OFS_CTRL, 8'h04);
        wr(`SITWU_OFS_DATA, 8'h81);
        timer_match <= 1'b1;
        @(posedge clk_sys);
        timer_match <= 1'b0;
        ticks(2);
        rd_chk(`SITWU_OFS_DATA, 8'h03);
        rd_chk(`SITWU_OFS_STAT, 8'h01);
        // no wire mode: start detector off, edge interrupt from preset counter
        wr(`SITWU_OFS_CTRL, 8'h48);
        wr(`SITWU_OFS_STAT, 8'h0f);
        m_u.start_cond();
        ticks(3);
        rd_chk(`SITWU_OFS_STAT, 8'h40);
        check({31'h0, irq_req}, 32'h1);
        m_u.stop_cond();
        ticks(3);
        rd_chk(`SITWU_OFS_STAT, 8'h41);
        wrap_up();
    end
endmodule
